// ### inc/power_manager_pkg.sv
// Package with register map, field positions, reset values and states of the power manager.
package power_manager_pkg;

  localparam int          ADDR_W          = 12;      // APB address width.
  localparam logic [11:0] CTRL_OFFSET     = 12'h000; // Mode control register byte address.
  localparam logic [11:0] STATUS_OFFSET   = 12'h004; // Stability status register byte address.
  localparam int          BIT_PSAVE       = 0;       // Power save request bit.
  localparam int          BIT_IDLE        = 1;       // Idle mode bit.
  localparam int          BIT_HALT        = 2;       // Halt mode bit.
  localparam int          BIT_WAIT        = 3;       // Wait before transition bit.
  localparam int          BIT_OSC_DIS     = 4;       // Oscillator disable bit.
  localparam int          BIT_PLL_DIS     = 5;       // PLL disable bit.
  localparam int          BIT_OSC_GATE    = 6;       // Oscillator hardware clock gate bit.
  localparam int          BIT_PLL_GATE    = 7;       // PLL hardware clock gate bit.
  localparam int          BIT_LOW_OK      = 0;       // Low-frequency stable flag.
  localparam int          BIT_OSC_OK      = 1;       // High-frequency oscillator stable flag.
  localparam int          BIT_PLL_OK      = 2;       // PLL stable flag.
  localparam logic [7:0]  CTRL_RESET      = 8'h00;   // Control register reset value.
  localparam int          SYNC_STAGES     = 2;       // Flip-flops in each input synchroniser.
  localparam int          NUM_ASYNC       = 5;       // Number of inputs crossing into core_clk.

  // Power modes as reported on the mode output.
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'b00,
    MODE_PSAVE  = 2'b01,
    MODE_IDLE   = 2'b10,
    MODE_HALT   = 2'b11
  } mode_t;

  // Internal sequencing states.
  typedef enum logic [2:0] {
    ST_ACTIVE    = 3'b000,
    ST_PSAVE     = 3'b001,
    ST_IDLE      = 3'b010,
    ST_HALT_STOP = 3'b011,
    ST_HALT      = 3'b100,
    ST_WAKE_OSC  = 3'b101,
    ST_WAKE_PLL  = 3'b110
  } state_t;

endpackage

// ### src/power_manager.sv
// Power mode control and clock stability status block with an APB register slave.
module power_manager (
  input  wire logic                               core_clk,       // System clock, 20 MHz.
  input  wire logic                               sys_rst,        // Asynchronous reset, active high.
  input  wire logic                               psel,           // APB select.
  input  wire logic                               penable,        // APB enable.
  input  wire logic                               pwrite,         // APB write direction.
  input  wire logic [power_manager_pkg::ADDR_W-1:0] paddr,        // APB byte address.
  input  wire logic [31:0]                        pwdata,         // APB write data.
  output logic      [31:0]                        prdata,         // APB read data.
  output logic                                    pready,         // APB ready.
  output logic                                    pslverr,        // APB error on unmapped address.
  input  wire logic                               waitExec,       // Wait instruction executed pulse.
  input  wire logic                               wakeRequest,    // Hardware wake-up, asynchronous.
  input  wire logic                               lowFreqOscOk,   // Low-frequency oscillator stable, async.
  input  wire logic                               highFreqOscOk,  // High-frequency oscillator stable, async.
  input  wire logic                               pllLock,        // PLL locked, asynchronous.
  input  wire logic                               linkSleep,      // Link controller asleep, asynchronous.
  input  wire logic                               pllPowerDown,   // PLL power-down bit of clock control.
  output logic                                    sysClkRun,      // System clock running.
  output logic                                    sysClkSlow,     // System clock taken from slow clock.
  output logic                                    slowClkRun,     // Slow clock running.
  output logic                                    oscEnable,      // High-frequency oscillator enable.
  output logic                                    pllEnable,      // PLL enable.
  output logic      [1:0]                         powerMode       // Current power mode code.
);
  import power_manager_pkg::*;

  logic [NUM_ASYNC-1:0] asyncIn;     // Raw asynchronous inputs.
  logic [NUM_ASYNC-1:0] syncMeta;    // First synchroniser stage.
  logic [NUM_ASYNC-1:0] syncOut;     // Second synchroniser stage.
  logic                 wakeS;       // Synchronised wake request.
  logic                 wakePrev;    // Wake request delayed for edge detection.
  logic                 wakeEvt;     // Rising edge of the wake request.
  logic                 lowOk;       // Synchronised low-frequency stability.
  logic                 oscOk;       // Synchronised oscillator stability.
  logic                 pllLockS;    // Synchronised PLL lock.
  logic                 sleepS;      // Synchronised link sleep.
  logic                 pllOk;       // PLL stable flag as software sees it.
  state_t               state;       // Sequencer state.
  state_t               next_state;  // Next sequencer state.
  logic                 psmBit;      // Power save bit.
  logic                 idleBit;     // Idle bit.
  logic                 haltBit;     // Halt bit.
  logic                 waitBefore;  // Wait before transition bit.
  logic                 oscDisable;  // Oscillator disable bit.
  logic                 pllDisable;  // PLL disable bit.
  logic                 oscGate;     // Oscillator hardware gate bit.
  logic                 pllGate;     // PLL hardware gate bit.
  logic                 psReq;       // Immediate power save request pending.
  logic                 exitReq;     // Software request to leave power save.
  logic                 waitSeen;    // Wait instruction seen while in Active.
  logic                 ctrlWrite;   // Write to the control register this cycle.
  logic                 enterActive; // Transition into Active this cycle.
  logic [7:0]           ctrlRead;    // Assembled control register image.
  logic [7:0]           statusRead;  // Assembled status register image.
  logic                 next_osc;    // Next oscillator enable.
  logic                 next_pll;    // Next PLL enable.

  assign asyncIn = {linkSleep, pllLock, highFreqOscOk, lowFreqOscOk, wakeRequest};

  // Two-stage synchronisers for every input that comes from another clock or a pin.
  // Only the second stage is read, so a metastable first stage never spreads.
  // They reset low, so the low-frequency and oscillator flags read clear for two edges after reset.
  // The wait pulse and PLL power-down come from core_clk logic and bypass them.
  genvar g;
  generate
    for (g = 0; g < NUM_ASYNC; g++) begin : gSync
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          syncMeta[g] <= 1'b0;
          syncOut[g]  <= 1'b0;
        end else begin
          syncMeta[g] <= asyncIn[g];
          syncOut[g]  <= syncMeta[g];
        end
      end
    end
  endgenerate

  assign wakeS    = syncOut[0];
  assign lowOk    = syncOut[1];
  assign oscOk    = syncOut[2];
  assign pllLockS = syncOut[3];
  assign sleepS   = syncOut[4];

  // A disabled PLL reports stable so that it drops out of the transition checks.
  assign pllOk = pllLockS | ~pllEnable;

  // The wake unit holds its request until acknowledged, so only the rising edge counts.
  // The history resets low, the idle level of the request, so that no false
  // wake-up event follows the release of reset.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakePrev <= 1'b0;
    end else begin
      wakePrev <= wakeS;
    end
  end

  assign wakeEvt     = wakeS & ~wakePrev;
  assign ctrlWrite   = psel & penable & pready & pwrite & (paddr == CTRL_OFFSET);
  assign enterActive = (state != ST_ACTIVE) && (next_state == ST_ACTIVE);

  // Mode sequencer: works out the next mode from requests, wake-up and stability.
  // Low-power entry waits while the slow clock is unstable; the request stays
  // pending. Wake-up always passes the oscillator and PLL stability waits, and
  // Active is entered only with both clocks stable.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_ACTIVE: begin
        // Immediate power save takes priority over the deferred requests.
        if (lowOk) begin
          if (psReq) begin
            next_state = ST_PSAVE;
          end else if (waitSeen && haltBit) begin
            next_state = ST_HALT_STOP;
          end else if (waitSeen && idleBit) begin
            next_state = ST_IDLE;
          end else if (waitSeen && psmBit && waitBefore) begin
            next_state = ST_PSAVE;
          end
        end
      end
      ST_PSAVE: begin
        if (wakeEvt) begin
          next_state = ST_WAKE_OSC;
        end else if (exitReq && oscOk && pllOk) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_IDLE: begin
        if (wakeEvt) begin
          next_state = ST_WAKE_OSC;
        end
      end
      ST_HALT_STOP: begin
        // System clock is stopped here; oscillator and PLL go off one cycle later.
        next_state = wakeEvt ? ST_WAKE_OSC : ST_HALT;
      end
      ST_HALT: begin
        if (wakeEvt) begin
          next_state = ST_WAKE_OSC;
        end
      end
      ST_WAKE_OSC: begin
        if (oscOk) begin
          next_state = ST_WAKE_PLL;
        end
      end
      ST_WAKE_PLL: begin
        // The oscillator must still be stable when Active is entered.
        if (pllOk && oscOk) begin
          next_state = ST_ACTIVE;
        end
      end
      default: begin
        next_state = ST_ACTIVE;
      end
    endcase
  end

  // State register.
  // Reset leaves the block in Active with no transition pending.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // Remembers a wait instruction so a request held back by stability still completes.
  // Only a wait seen while a deferred request is pending is kept, so a stray
  // earlier wait cannot let a later request enter without its own wait.
  // The flag clears on entry and whenever the sequencer is outside Active.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitSeen <= 1'b0;
    end else if (state != ST_ACTIVE) begin
      waitSeen <= 1'b0;
    end else if (next_state != ST_ACTIVE) begin
      waitSeen <= 1'b0;
    end else if (waitExec && (idleBit || haltBit || (psmBit && waitBefore))) begin
      waitSeen <= 1'b1;
    end
  end

  // Power save bit and its pending immediate and exit requests.
  // Immediate requests read set only after entry, deferred ones from the write.
  // Clearing the bit in Power Save raises an exit request; the bit itself
  // drops only once Active has been reached.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      psmBit  <= CTRL_RESET[BIT_PSAVE];
      psReq   <= 1'b0;
      exitReq <= 1'b0;
    end else begin
      if (enterActive || (wakeEvt && state == ST_ACTIVE)) begin
        // Bit drops only once Active is reached.
        psmBit  <= 1'b0;
        psReq   <= 1'b0;
        exitReq <= 1'b0;
      end else if (state == ST_ACTIVE && next_state == ST_PSAVE) begin
        psmBit <= 1'b1;
        psReq  <= 1'b0;
      end else if (ctrlWrite && state == ST_ACTIVE) begin
        if (pwdata[BIT_PSAVE] && pwdata[BIT_WAIT]) begin
          psmBit <= 1'b1;
          psReq  <= 1'b0;
        end else if (pwdata[BIT_PSAVE]) begin
          psReq  <= 1'b1;
        end else begin
          psmBit <= 1'b0;
          psReq  <= 1'b0;
        end
      end else if (ctrlWrite && state == ST_PSAVE && !pwdata[BIT_PSAVE]) begin
        exitReq <= 1'b1;
      end
    end
  end

  // Idle and halt bits; a request of either is taken only from Active.
  // Writes of zero are always taken. Wake-up clears the idle bit at once;
  // the halt bit stays set until the oscillator is stable again.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idleBit <= CTRL_RESET[BIT_IDLE];
      haltBit <= CTRL_RESET[BIT_HALT];
    end else begin
      if (wakeEvt) begin
        idleBit <= 1'b0;
      end else if (ctrlWrite && (state == ST_ACTIVE || !pwdata[BIT_IDLE])) begin
        idleBit <= pwdata[BIT_IDLE];
      end
      if (state == ST_WAKE_OSC && oscOk) begin
        haltBit <= 1'b0;
      end else if (ctrlWrite && (state == ST_ACTIVE || !pwdata[BIT_HALT])) begin
        haltBit <= pwdata[BIT_HALT];
      end
    end
  end

  // Wait bit, clock disable bits and hardware clock gate bits.
  // Wake-up clears the oscillator disable at once and the PLL disable once
  // the oscillator is stable. The gate bits clear on every entry into Active.
  // A hardware clear wins over a software write in the same cycle.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitBefore <= CTRL_RESET[BIT_WAIT];
      oscDisable <= CTRL_RESET[BIT_OSC_DIS];
      pllDisable <= CTRL_RESET[BIT_PLL_DIS];
      oscGate    <= CTRL_RESET[BIT_OSC_GATE];
      pllGate    <= CTRL_RESET[BIT_PLL_GATE];
    end else begin
      if (ctrlWrite) begin
        waitBefore <= pwdata[BIT_WAIT];
      end
      if (wakeEvt) begin
        oscDisable <= 1'b0;
      end else if (ctrlWrite) begin
        oscDisable <= pwdata[BIT_OSC_DIS];
      end
      if ((state == ST_WAKE_OSC && oscOk) || (wakeEvt && state == ST_ACTIVE)) begin
        pllDisable <= 1'b0;
      end else if (ctrlWrite) begin
        pllDisable <= pwdata[BIT_PLL_DIS];
      end
      if (enterActive) begin
        oscGate <= 1'b0;
        pllGate <= 1'b0;
      end else if (ctrlWrite) begin
        oscGate <= pwdata[BIT_OSC_GATE];
        pllGate <= pwdata[BIT_PLL_GATE];
      end
    end
  end

  // Clock enables for the next cycle, decided from the next state.
  // Active keeps the oscillator, and the PLL unless powered down, running whatever the disable bits say; Halt turns them
  // off a cycle after the system clock stops. Gates act only while the link
  // sleeps, and the disable bits override them.
  always_comb begin
    next_osc = 1'b1;
    next_pll = ~pllPowerDown;
    unique case (next_state)
      ST_ACTIVE, ST_HALT_STOP: begin
        // Active ignores the disable bits; halt keeps clocks until sysclk has stopped.
        next_osc = 1'b1;
        next_pll = ~pllPowerDown;
      end
      ST_PSAVE, ST_IDLE: begin
        // Disables take effect only once the low-power state is really entered.
        next_osc = ~oscDisable & ~(oscGate & sleepS);
        next_pll = ~pllDisable & ~pllPowerDown & ~(pllGate & sleepS);
      end
      ST_HALT: begin
        next_osc = 1'b0;
        next_pll = 1'b0;
      end
      ST_WAKE_OSC: begin
        next_osc = 1'b1;
        next_pll = 1'b0;
      end
      ST_WAKE_PLL: begin
        next_osc = 1'b1;
        next_pll = ~pllPowerDown;
      end
      default: begin
        next_osc = 1'b1;
        next_pll = ~pllPowerDown;
      end
    endcase
  end

  // Registered clock controls and mode code.
  // Every output comes from a flip-flop, one cycle behind next_state.
  // Wake states keep the mode code of the state being left, so Active is
  // shown only once the whole wake sequence has finished.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oscEnable  <= 1'b1;
      pllEnable  <= 1'b0;
      sysClkRun  <= 1'b1;
      sysClkSlow <= 1'b0;
      slowClkRun <= 1'b1;
      powerMode  <= MODE_ACTIVE;
    end else begin
      oscEnable  <= next_osc;
      pllEnable  <= next_pll;
      sysClkRun  <= (next_state == ST_ACTIVE) || (next_state == ST_PSAVE);
      sysClkSlow <= (next_state == ST_PSAVE);
      slowClkRun <= (next_state != ST_HALT_STOP) && (next_state != ST_HALT);
      unique case (next_state)
        ST_ACTIVE:              powerMode <= MODE_ACTIVE;
        ST_PSAVE:               powerMode <= MODE_PSAVE;
        ST_IDLE:                powerMode <= MODE_IDLE;
        ST_HALT_STOP, ST_HALT:  powerMode <= MODE_HALT;
        default:                powerMode <= powerMode;
      endcase
    end
  end

  // Register images as software reads them.
  // Reserved status bits read zero. A disabled PLL reads stable, so it never
  // holds back a transition.
  assign ctrlRead = {pllGate, oscGate, pllDisable, oscDisable,
                     waitBefore, haltBit, idleBit, psmBit};
  assign statusRead = {5'h00, pllOk, oscOk, lowOk};

  // APB slave: ready one cycle after setup, so the access phase completes at once.
  // Read data and error are registered with ready; the error stands one cycle, the data until the next setup.
  // Unmapped addresses answer with an error and zero data.
  // Writes land at the access edge through ctrlWrite; status writes are dropped.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (psel && !penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= (paddr != CTRL_OFFSET) && (paddr != STATUS_OFFSET);
      if (paddr == CTRL_OFFSET) begin
        prdata <= {24'h000000, ctrlRead};
      end else if (paddr == STATUS_OFFSET) begin
        prdata <= {24'h000000, statusRead};
      end else begin
        prdata <= 32'h00000000;
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// ### verification/power_manager_sva.sv
// Concurrent checks on the ports of the power manager.
module power_manager_sva (
  input wire logic                                 core_clk,      // Clock.
  input wire logic                                 sys_rst,       // Reset.
  input wire logic                                 psel,          // APB select.
  input wire logic                                 penable,       // APB enable.
  input wire logic [power_manager_pkg::ADDR_W-1:0] paddr,         // APB address.
  input wire logic                                 pready,        // APB ready.
  input wire logic                                 pslverr,       // APB error.
  input wire logic                                 lowFreqOscOk,  // Low-frequency stable.
  input wire logic                                 highFreqOscOk, // Oscillator stable.
  input wire logic                                 pllPowerDown,  // PLL power-down.
  input wire logic                                 sysClkRun,     // System clock running.
  input wire logic                                 oscEnable,     // Oscillator enable.
  input wire logic                                 pllEnable,     // PLL enable.
  input wire logic [1:0]                           powerMode      // Mode code.
);
  timeunit 1ns;
  timeprecision 1ns;
  import power_manager_pkg::*;

  // All checks share the one clock and its reset.
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // A setup cycle of a bus transfer.
  sequence setupS;
    psel && !penable;
  endsequence

  // The mode leaves Active.
  sequence leaveActiveS;
    $past(powerMode) == MODE_ACTIVE && powerMode != MODE_ACTIVE;
  endsequence

  // The mode returns to Active.
  sequence enterActiveS;
    $past(powerMode) != MODE_ACTIVE && powerMode == MODE_ACTIVE;
  endsequence

  AST_APB_LATENCY: assert property (setupS |=> pready)
    else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_UNMAPPED: assert property (pready |-> pslverr == (paddr != CTRL_OFFSET && paddr != STATUS_OFFSET))
    else $error("error flag wrong for address");
  AST_ACTIVE_OSC: assert property (powerMode == MODE_ACTIVE |-> oscEnable)
    else $error("osc off in Active");
  AST_ACTIVE_PLL: assert property (powerMode == MODE_ACTIVE && !$past(sys_rst)
    |-> pllEnable == !$past(pllPowerDown)) else $error("PLL enable wrong in Active");
  AST_PLL_POWERDOWN: assert property (pllPowerDown |=> !pllEnable)
    else $error("PLL on while powered down");
  AST_HALT_ORDER: assert property ($fell(sysClkRun) && powerMode == MODE_HALT
    |-> oscEnable ##1 (!oscEnable && !pllEnable)) else $error("halt stopped clocks out of order");
  AST_HALT_CLOCK: assert property (powerMode == MODE_HALT |-> !sysClkRun)
    else $error("system clock runs in Halt");
  // Pin to mode change: two synchroniser edges, the decision edge, the sampling edge.
  AST_LOWPOWER_LOWOK: assert property (leaveActiveS |-> $past(lowFreqOscOk, 3))
    else $error("low power without slow clock");
  AST_ACTIVE_OSCOK: assert property (enterActiveS |-> $past(highFreqOscOk, 3))
    else $error("Active without stable osc");
endmodule

bind power_manager power_manager_sva sva (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .lowFreqOscOk(lowFreqOscOk), .highFreqOscOk(highFreqOscOk),
  .pllPowerDown(pllPowerDown), .sysClkRun(sysClkRun), .oscEnable(oscEnable), .pllEnable(pllEnable),
  .powerMode(powerMode));

// ### verification/power_manager_tb_top.sv
// Self-checking bench for the power manager.
module power_manager_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import power_manager_pkg::*;

  logic        core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, sysClkRun, sysClkSlow, slowClkRun, oscEnable, pllEnable;
  logic        waitExec = 1'b0, wakeRequest = 1'b0, lowFreqOscOk = 1'b0, highFreqOscOk = 1'b1;
  logic        pllLock = 1'b1, linkSleep = 1'b0, pllPowerDown = 1'b0;
  logic [1:0]  powerMode;
  int          n_fail = 0, n_compared = 0, cycles = 0;

  // Clock at 20 MHz.
  always #25 core_clk = ~core_clk;

  power_manager dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .waitExec(waitExec),
    .wakeRequest(wakeRequest), .lowFreqOscOk(lowFreqOscOk), .highFreqOscOk(highFreqOscOk), .pllLock(pllLock),
    .linkSleep(linkSleep), .pllPowerDown(pllPowerDown), .sysClkRun(sysClkRun), .sysClkSlow(sysClkSlow),
    .slowClkRun(slowClkRun), .oscEnable(oscEnable), .pllEnable(pllEnable), .powerMode(powerMode));

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request holds until ready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register read compared with an expected word.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  // Register write.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  // Lets a number of clock edges pass.
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Waits, bounded, for a mode and checks it was reached.
  task automatic wait_mode(input logic [1:0] m);
    int k;
    for (k = 0; k < 40 && powerMode !== m; k++) @(posedge core_clk);
    chk({30'h0, powerMode}, {30'h0, m});
  endtask

  // One-cycle wait instruction pulse.
  task automatic pulse_wait();
    @(posedge core_clk);
    waitExec <= 1'b1;
    @(posedge core_clk);
    waitExec <= 1'b0;
  endtask

  // Reset values, status contents and refused accesses.
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rd(CTRL_OFFSET, 32'h00);
    rd(STATUS_OFFSET, 32'h06);
    wr(STATUS_OFFSET, 32'hff);
    rd(STATUS_OFFSET, 32'h06);
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk(e, 1'b1);
  endtask

  // Immediate Power Save, clock disables, link gates, wake with slow PLL.
  task automatic t_psave();
    wr(CTRL_OFFSET, 32'h01);
    step(8);
    chk(powerMode, MODE_ACTIVE);
    rd(CTRL_OFFSET, 32'h00);
    lowFreqOscOk <= 1'b1;
    wait_mode(MODE_PSAVE);
    rd(CTRL_OFFSET, 32'h01);
    chk(sysClkSlow, 1'b1);
    wr(CTRL_OFFSET, 32'h03);
    rd(CTRL_OFFSET, 32'h01);
    wr(CTRL_OFFSET, 32'h11);
    step(3);
    chk(oscEnable, 1'b0);
    wr(CTRL_OFFSET, 32'h21);
    pllLock <= 1'b0;
    step(4);
    chk(pllEnable, 1'b0);
    rd(STATUS_OFFSET, 32'h07);
    wr(CTRL_OFFSET, 32'hc1);
    linkSleep <= 1'b1;
    step(5);
    chk({oscEnable, pllEnable}, 2'b00);
    linkSleep <= 1'b0;
    pllPowerDown <= 1'b1;
    step(4);
    chk({oscEnable, pllEnable}, 2'b10);
    pllPowerDown <= 1'b0;
    step(4);
    rd(STATUS_OFFSET, 32'h03);
    wakeRequest <= 1'b1;
    step(8);
    chk(powerMode == MODE_ACTIVE, 1'b0);
    pllLock <= 1'b1;
    wait_mode(MODE_ACTIVE);
    rd(CTRL_OFFSET, 32'h00);
    wakeRequest <= 1'b0;
  endtask

  // Deferred Idle entry and the wake-up sequence.
  task automatic t_idle();
    wr(CTRL_OFFSET, 32'h3a);
    rd(CTRL_OFFSET, 32'h3a);
    step(6);
    chk(powerMode, MODE_ACTIVE);
    pulse_wait();
    wait_mode(MODE_IDLE);
    step(2);
    chk({sysClkRun, oscEnable, pllEnable}, 3'b000);
    highFreqOscOk <= 1'b0;
    pllLock <= 1'b0;
    step(4);
    wakeRequest <= 1'b1;
    step(8);
    rd(CTRL_OFFSET, 32'h28);
    chk({oscEnable, pllEnable}, 2'b10);
    chk(powerMode == MODE_ACTIVE, 1'b0);
    highFreqOscOk <= 1'b1;
    step(6);
    rd(CTRL_OFFSET, 32'h08);
    chk(pllEnable, 1'b1);
    pllLock <= 1'b1;
    wait_mode(MODE_ACTIVE);
    wakeRequest <= 1'b0;
  endtask

  // Halt entry order and the halt bit held until the oscillator is stable.
  task automatic t_halt();
    int k;
    wr(CTRL_OFFSET, 32'h3c);
    pulse_wait();
    for (k = 0; k < 20 && sysClkRun !== 1'b0; k++) @(posedge core_clk);
    chk(oscEnable, 1'b1);
    @(posedge core_clk);
    chk({oscEnable, pllEnable, slowClkRun}, 3'b000);
    chk(powerMode, MODE_HALT);
    highFreqOscOk <= 1'b0;
    pllLock <= 1'b0;
    step(4);
    wakeRequest <= 1'b1;
    step(8);
    rd(CTRL_OFFSET, 32'h2c);
    chk(oscEnable, 1'b1);
    highFreqOscOk <= 1'b1;
    step(6);
    rd(CTRL_OFFSET, 32'h08);
    pllLock <= 1'b1;
    wait_mode(MODE_ACTIVE);
    wakeRequest <= 1'b0;
  endtask

  // Deferred Power Save entry and a software exit held back by the oscillator.
  task automatic t_exit();
    wr(CTRL_OFFSET, 32'h09);
    rd(CTRL_OFFSET, 32'h09);
    step(4);
    chk(powerMode, MODE_ACTIVE);
    pulse_wait();
    wait_mode(MODE_PSAVE);
    highFreqOscOk <= 1'b0;
    wr(CTRL_OFFSET, 32'h08);
    step(6);
    chk(powerMode, MODE_PSAVE);
    rd(CTRL_OFFSET, 32'h09);
    highFreqOscOk <= 1'b1;
    wait_mode(MODE_ACTIVE);
    rd(CTRL_OFFSET, 32'h08);
  endtask

  // Cuts a hung run short.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Main sequence.
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    step(3);
    t_reset();
    t_psave();
    t_idle();
    t_halt();
    t_exit();
    step(4);
    tally_and_finish();
  end
endmodule
